// ---- design/lpcg_pkg.sv ----
// Package for the processor low-power clock gate controller
package lpcg_pkg;

	// Bus geometry
	localparam int ADDR_W = 24;
	localparam int FC_W   = 3;
	localparam int IPL_W  = 3;

	// Supervisor data space code on the cycle space lines
	localparam logic [2:0] FC_SUP_DATA = 3'h5;

	// Bus cycles from the trigger write up to the operand fetch
	// Trigger write, opcode fetch, immediate operand (16-bit bus)
	localparam logic [2:0] CYC_16 = 3'h3;
	// One extra bus cycle for the second operand byte (8-bit bus)
	localparam logic [2:0] CYC_8  = 3'h4;

	// Clock stable wait after the system clock restarts
	localparam int STABLE_NS     = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int STABLE_CYC    = (STABLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// Default trigger address and wake level
	localparam logic [23:0] TRIG_ADDR_DEF = 24'hFFFFF0;
	localparam logic [2:0]  WAKE_LVL_DEF  = 3'h7;

	// Processor bus view sampled by the controller
	typedef struct packed {
		logic [23:0] address_lines;
		logic [2:0]  cycle_space_code;
		logic        rd_wr_n;
		logic        strobe_n;
	} lpcg_bus_s;

	// Controller states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_COUNT,
		ST_ARB,
		ST_STOPPED,
		ST_STABLE,
		ST_WAKE,
		ST_RELEASE
	} lpcg_state_e;

endpackage

// ---- design/lpcg_match.sv ----
// Trigger address detector for supervisor data writes
`timescale 1ns/10ps
module lpcg_match (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	// Bus view and trigger address
	input  wire lpcg_pkg::lpcg_bus_s bus_i,
	input  wire logic [23:0]         trig_addr_i,
	// Registered hit pulse and bus-cycle end pulse
	output logic                     hit_o,
	output logic                     cyc_end_o
);
	import lpcg_pkg::*;

	logic strobe_d_ff;  // Strobe seen last cycle
	logic nxt_strobe_d;
	logic hit_ff;       // Registered hit
	logic nxt_hit;
	logic cyc_end_ff;   // Registered end of a bus cycle
	logic nxt_cyc_end;

	// Hit on the first cycle of a matching supervisor data write
	always_comb begin
		nxt_strobe_d = ~bus_i.strobe_n;
		nxt_hit = ~bus_i.strobe_n & ~strobe_d_ff
			& (bus_i.address_lines == trig_addr_i)
			& ~bus_i.rd_wr_n
			& (bus_i.cycle_space_code == FC_SUP_DATA);
		nxt_cyc_end = bus_i.strobe_n & strobe_d_ff;
	end

	// Register the detector
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_d_ff <= 1'b0;
			hit_ff      <= 1'b0;
			cyc_end_ff  <= 1'b0;
		end else begin
			strobe_d_ff <= nxt_strobe_d;
			hit_ff      <= nxt_hit;
			cyc_end_ff  <= nxt_cyc_end;
		end
	end

	assign hit_o     = hit_ff;
	assign cyc_end_o = cyc_end_ff;

	// Hit only follows a supervisor write at the trigger address
	a_hit_qual: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		hit_o |-> $past(bus_i.cycle_space_code) == FC_SUP_DATA
		&& !$past(bus_i.rd_wr_n) && !$past(bus_i.strobe_n)
		&& $past(bus_i.address_lines) == trig_addr_i)
		else $error("hit without supervisor data write");

endmodule

// ---- design/lpcg_gate.sv ----
// Glitch-free clock gate for the processor clock
`timescale 1ns/10ps
module lpcg_gate (
	// System clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Enable request in the clk_i domain
	input  wire logic run_i,
	// Gated processor clock and gate state
	output logic      cpu_clk_o,
	output logic      gate_on_o
);
	logic en_ff;  // Enable changed only while the clock is low
	logic nxt_en; // Next enable value

	// Next enable is the run request
	always_comb begin
		nxt_en = run_i;
	end

	// Latch-free gate: enable sampled on the falling edge
	always_ff @(negedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_ff <= 1'b1;
		end else begin
			en_ff <= nxt_en;
		end
	end

	// Clock is low when en_ff changes, so no runt pulse appears
	assign cpu_clk_o = clk_i & en_ff;
	assign gate_on_o = en_ff;

endmodule

// ---- design/lpcg_ctrl.sv ----
// Low-power entry and wake controller for the embedded processor
`timescale 1ns/10ps
// How it works
// - Processor is in supervisor mode first
// - Software enters through a trap handler
// - Trigger address anywhere in 24-bit space
// - Hit on supervisor data write to trigger
// - Count cycles, stop clock after operand fetch
// - Eight-bit bus adds one counted cycle
// - Clock gating never passes runts or glitches
// - Optional arbitration during status-word fetch
// - Watch priority lines for wake level
// - Wait for stable clock before wake
// - Clock resumes at next falling edge
// - Drop bus request once the clock resumes
// - Two-wire arbitration, request and grant
// - Handler writes trigger, halts, returns
module lpcg_ctrl #(
	parameter logic [23:0] TRIG_ADDR  = lpcg_pkg::TRIG_ADDR_DEF,
	parameter logic [2:0]  WAKE_LVL   = lpcg_pkg::WAKE_LVL_DEF,
	parameter int          STABLE_CNT = lpcg_pkg::STABLE_CYC
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	// Processor bus view
	input  wire lpcg_pkg::lpcg_bus_s bus_i,
	input  wire logic [2:0]          interrupt_priority_lines_i,
	input  wire logic                bus_grant_n_i,
	// Configuration straps and system clock stable input
	input  wire logic                bus8_i,
	input  wire logic                float_en_i,
	input  wire logic                sysclk_stable_i,
	// Processor clock and arbitration
	output logic                     cpu_clk_o,
	output logic                     bus_request_line_n_o,
	// Status
	output logic                     low_power_o,
	output logic                     sysclk_run_o
);
	import lpcg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////////
	lpcg_state_e state_ff;     // Controller state
	lpcg_state_e nxt_state;
	logic [2:0]  cyc_ff;       // Bus cycles seen since the trigger
	logic [2:0]  nxt_cyc;
	logic [15:0] wait_ff;      // Clock stable wait counter
	logic [15:0] nxt_wait;
	logic        run_ff;       // Processor clock enable request
	logic        nxt_run;
	logic        breq_ff;      // Bus request held
	logic        nxt_breq;
	logic        sysrun_ff;    // System clock run request
	logic        nxt_sysrun;
	logic        hit;          // Trigger write seen
	logic        cyc_end;      // End of a bus cycle
	logic        gate_on;      // Processor clock is passing
	logic [2:0]  cyc_target;   // Cycles to count before stop
	logic        wake_lvl_hit; // Wake level on priority lines

	////////////////////////////////////////////////////////////////////
	// Submodules
	////////////////////////////////////////////////////////////////////
	// Trigger write detector
	lpcg_match u_match (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.bus_i       (bus_i),
		.trig_addr_i (TRIG_ADDR),
		.hit_o       (hit),
		.cyc_end_o   (cyc_end)
	);

	// Processor clock gate
	lpcg_gate u_gate (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.run_i     (run_ff),
		.cpu_clk_o (cpu_clk_o),
		.gate_on_o (gate_on)
	);

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	////////////////////////////////////////////////////////////////////
	// Eight-bit bus fetches the operand in two cycles
	assign cyc_target   = bus8_i ? CYC_8 : CYC_16;
	// Priority lines are active low; level match wakes
	assign wake_lvl_hit = (~interrupt_priority_lines_i) == WAKE_LVL;

	// Sequence the entry, stop and wake
	always_comb begin
		nxt_state  = state_ff;
		nxt_cyc    = cyc_ff;
		nxt_wait   = wait_ff;
		nxt_run    = run_ff;
		nxt_breq   = breq_ff;
		nxt_sysrun = sysrun_ff;
		case (state_ff)
			// Normal running, wait for the trigger write
			ST_RUN: begin
				nxt_cyc = 3'h0;
				if (hit) begin
					nxt_state = ST_COUNT;
				end
			end
			// Count bus cycles from the trigger write
			ST_COUNT: begin
				if (cyc_end) begin
					nxt_cyc = cyc_ff + 3'h1;
					// Request the bus during the status fetch
					if (float_en_i && (cyc_ff + 3'h1 == cyc_target
						- 3'h1)) begin
						nxt_breq = 1'b1;
					end
					if (cyc_ff + 3'h1 == cyc_target) begin
						nxt_state = float_en_i ? ST_ARB : ST_STOPPED;
						nxt_run   = float_en_i;
					end
				end
			end
			// Wait for grant before stopping the clock
			ST_ARB: begin
				if (!bus_grant_n_i) begin
					nxt_run   = 1'b0;
					nxt_state = ST_STOPPED;
				end
			end
			// Clock stopped; state held inside the processor
			ST_STOPPED: begin
				nxt_sysrun = 1'b0;
				if (wake_lvl_hit) begin
					nxt_sysrun = 1'b1;
					nxt_wait   = 16'h0000;
					nxt_state  = ST_STABLE;
				end
			end
			// Wait for the system clock to settle
			ST_STABLE: begin
				if (!sysclk_stable_i) begin
					nxt_wait = 16'h0000;
				end else if (wait_ff >= 16'(STABLE_CNT - 1)) begin
					nxt_state = ST_WAKE;
				end else begin
					nxt_wait = wait_ff + 16'h0001;
				end
			end
			// Assert wake; the gate opens on the next falling edge
			ST_WAKE: begin
				nxt_run = 1'b1;
				if (gate_on) begin
					nxt_breq  = 1'b0;
					nxt_state = ST_RELEASE;
				end
			end
			// Bus released; clear counters for the next entry
			ST_RELEASE: begin
				nxt_cyc   = 3'h0;
				nxt_wait  = 16'h0000;
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	// Register the controller state
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff  <= ST_RUN;
			cyc_ff    <= 3'h0;
			wait_ff   <= 16'h0000;
			run_ff    <= 1'b1;
			breq_ff   <= 1'b0;
			sysrun_ff <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			cyc_ff    <= nxt_cyc;
			wait_ff   <= nxt_wait;
			run_ff    <= nxt_run;
			breq_ff   <= nxt_breq;
			sysrun_ff <= nxt_sysrun;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////
	assign bus_request_line_n_o = ~breq_ff;
	assign low_power_o          = (state_ff == ST_STOPPED)
		|| (state_ff == ST_STABLE);
	assign sysclk_run_o         = sysrun_ff;

	////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////
	// A trigger write always starts the count
	a_hit_start: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_RUN && hit |=> state_ff == ST_COUNT)
		else $error("trigger write did not start the count");

	// Without a trigger the controller stays idle
	a_idle_hold: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_RUN && !hit |=> state_ff == ST_RUN)
		else $error("count started without a trigger write");

	// Clock stops right after the counted operand fetch
	a_stop_after_cnt: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_COUNT && cyc_end && !float_en_i
		&& cyc_ff + 3'h1 == cyc_target |=> !run_ff)
		else $error("clock not stopped after operand fetch");

	// Stop count matches the strapped bus width
	a_cnt_8bit: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(state_ff == ST_STOPPED) && $past(state_ff) == ST_COUNT
		|-> $past(cyc_ff) == (bus8_i ? 3'h3 : 3'h2))
		else $error("wrong cycle count for bus width");

	// Counter never runs past its target
	a_cyc_bound: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		cyc_ff <= cyc_target)
		else $error("bus cycle counter past its target");

	// Bus request only in float mode, raised from the count
	a_breq_float: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		$fell(bus_request_line_n_o) |-> $past(float_en_i)
		&& $past(state_ff) == ST_COUNT)
		else $error("bus request outside the status fetch");

	// Clock keeps running until the grant arrives
	a_arb_wait: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_ARB && bus_grant_n_i
		|=> state_ff == ST_ARB && run_ff)
		else $error("clock stopped before bus grant");

	// Grant stops the clock
	a_arb_stop: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_ARB && !bus_grant_n_i
		|=> state_ff == ST_STOPPED && !run_ff)
		else $error("clock not stopped after bus grant");

	// Stopped clock keeps the processor frozen
	a_stop_held: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_STOPPED |-> !run_ff)
		else $error("clock runs while stopped");

	// Gate follows the run request half a cycle later
	a_gate_follow: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		gate_on == run_ff)
		else $error("gate out of step with run request");

	// Wake level leads to the stable wait
	a_wake_level: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_STOPPED && wake_lvl_hit
		|=> state_ff == ST_STABLE && sysrun_ff)
		else $error("wake level not recognised");

	// System clock kept running for the whole stable wait
	a_sysrun_on: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_STABLE |-> sysrun_ff)
		else $error("system clock not running during wait");

	// An unstable clock restarts the wait
	a_wait_restart: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_STABLE && !sysclk_stable_i
		|=> state_ff == ST_STABLE && wait_ff == 16'h0000)
		else $error("wait not restarted on unstable clock");

	// No wake before the full stable count
	a_wait_full: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_STABLE && wait_ff < 16'(STABLE_CNT - 1)
		|=> state_ff == ST_STABLE)
		else $error("wake before the stable count ran out");

	// Wake is only entered with a stable clock
	a_wake_stable: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_WAKE |-> sysclk_stable_i
		|| $past(state_ff) == ST_WAKE)
		else $error("wake before clock stable");

	// Gate opens on the falling edge after the wake request
	a_gate_resume: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_WAKE && run_ff |=> gate_on)
		else $error("clock not resumed at falling edge");

	// Bus request is gone once the clock runs again
	a_breq_drop: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_RELEASE |-> bus_request_line_n_o)
		else $error("bus request held at resume");

	// Processor in normal running (ST_RUN) never sees a bus request
	a_breq_run: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_RUN |-> bus_request_line_n_o)
		else $error("bus request held while running");

	// Counter cleared and idle again after the wake
	a_reset_ready: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		state_ff == ST_RELEASE |=> cyc_ff == 3'h0
		&& state_ff == ST_RUN)
		else $error("counter not cleared after wake");

endmodule

// ---- bench/lpcg_cpu_model.sv ----
// Behavioural processor bus model running from the gated clock
`timescale 1ns/10ps
module lpcg_cpu_model (
	// Gated processor clock and bus request
	input  wire logic          cpu_clk_i,
	input  wire logic          breq_n_i,
	// Bus view and bus grant
	output lpcg_pkg::lpcg_bus_s bus_o,
	output logic               grant_n_o
);
	import lpcg_pkg::*;

	// Clocks seen; nothing moves while the clock is stopped
	int unsigned ticks;

	// Idle bus and no grant at time zero
	initial begin
		bus_o = '{24'h0, 3'h1, 1'b1, 1'b1};
		grant_n_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// State only advances on processor clock edges
	always @(posedge cpu_clk_i) ticks <= ticks + 1;

	// Two-wire arbitration: grant follows request at the next falling clock edge
	always @(negedge cpu_clk_i) grant_n_o <= breq_n_i;

	////////////////////////////////////////////////////////////////////
	// One bus cycle; a byte-wide operand costs the caller a second one
	task automatic cycle(input logic [23:0] a, input logic [2:0] fc,
		input logic rw);
		@(negedge cpu_clk_i);
		bus_o <= '{a, fc, rw, 1'b0};
		repeat (2) @(negedge cpu_clk_i);
		// Released address and space lines show the inverse of the last value
		bus_o <= '{~a, ~fc, rw, 1'b1};
	endtask
endmodule

// ---- bench/test_cpu_low_power_clock_gate.sv ----
// Self-checking bench for the low-power clock gate controller
`timescale 1ns/10ps
module test_cpu_low_power_clock_gate;
	import lpcg_pkg::*;

	localparam logic [23:0] TRIG = 24'h00A5C3; // Trigger address
	localparam logic [2:0]  WAKE = 3'h7;       // Wake level
	localparam int          STB  = 4;          // Shortened stable wait

	logic       clk, rstn, grant_n, bus8, float_en, stable;
	logic       cpu_clk, breq_n, low_power, sysclk_run;
	logic [2:0] ipl;       // Active low priority lines
	lpcg_bus_s  bus;       // Bus from the processor model
	int         fail_count, check_count, edges;
	realtime    t_up;      // Time of last processor clock rise

	////////////////////////////////////////////////////////////////////
	// Clock, design and processor model
	always #5 clk = ~clk;

	lpcg_ctrl #(.TRIG_ADDR(TRIG), .WAKE_LVL(WAKE), .STABLE_CNT(STB))
	i_dut (
		.clk_i(clk), .rstn_i(rstn), .bus_i(bus),
		.interrupt_priority_lines_i(ipl), .bus_grant_n_i(grant_n),
		.bus8_i(bus8), .float_en_i(float_en), .sysclk_stable_i(stable),
		.cpu_clk_o(cpu_clk), .bus_request_line_n_o(breq_n),
		.low_power_o(low_power), .sysclk_run_o(sysclk_run));

	lpcg_cpu_model i_cpu (.cpu_clk_i(cpu_clk), .breq_n_i(breq_n),
		.bus_o(bus), .grant_n_o(grant_n));

	////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Bus cycles from trigger write to operand fetch
	function automatic int n_cyc(input logic b8);
		return b8 ? 4 : 3;
	endfunction

	// Every processor clock high phase is a full half period
	always @(posedge cpu_clk) begin
		t_up = $realtime;
		edges++;
	end
	always @(negedge cpu_clk) if (rstn) check($realtime - t_up == 5.0, 1);

	////////////////////////////////////////////////////////////////////
	// Entry: trigger write, fetches, then a stopped clock
	task automatic enter(input logic b8, input logic flt);
		int k;
		int e0;
		bus8 = b8;
		float_en = flt;
		i_cpu.cycle(TRIG, FC_SUP_DATA, 1'b0);
		for (k = 1; k < n_cyc(b8); k++) begin
			check(low_power, 1'b0);
			i_cpu.cycle(24'($urandom), 3'h6, 1'b1);
		end
		for (k = 0; k < 20 && low_power !== 1'b1; k++) @(negedge clk);
		check(low_power, 1'b1);
		check(breq_n, !flt);
		e0 = edges;
		repeat (8) @(negedge clk);
		check(edges, e0);
	endtask

	// Wake: wrong level, unstable clock, then restart
	task automatic wake;
		int k;
		int e0;
		stable = 1'b0;
		ipl = ~3'h3;
		repeat (6) @(negedge clk);
		check(low_power, 1'b1);
		check(sysclk_run, 1'b0);
		ipl = ~WAKE;
		repeat (STB + 4) @(negedge clk);
		check(low_power, 1'b1);
		check(sysclk_run, 1'b1);
		stable = 1'b1;
		e0 = edges;
		repeat (STB - 1) @(negedge clk);
		check(edges, e0);
		for (k = 0; k < 20 && edges == e0; k++) @(negedge clk);
		check(edges != e0, 1);
		for (k = 0; k < 20 && breq_n !== 1'b1; k++) @(negedge clk);
		check(breq_n, 1'b1);
		repeat (4) @(negedge clk);
		check(low_power, 1'b0);
		ipl = 3'h7;
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int r;
		logic [23:0] a;
		{clk, rstn, bus8, float_en, stable, fail_count} = '0;
		{check_count, edges, r} = '0;
		ipl = 3'h0;
		r = $urandom(37125);
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		// Non-matching traffic while the wake level is active
		repeat (12) begin
			r = $urandom % 3;
			a = 24'($urandom);
			if (a == TRIG) a = a ^ 24'h1;
			if (r == 0) i_cpu.cycle(a, FC_SUP_DATA, 1'b0);
			if (r == 1) i_cpu.cycle(TRIG, FC_SUP_DATA, 1'b1);
			if (r == 2) i_cpu.cycle(TRIG, 3'h1, 1'b0);
		end
		repeat (4) @(negedge clk);
		check(low_power, 1'b0);
		ipl = 3'h7;
		for (r = 0; r < 4; r++) begin
			enter(r[0], r[1]);
			wake();
		end
		// Reset while stopped clears the stop state
		enter(1'b0, 1'b1);
		rstn = 1'b0;
		@(negedge clk);
		check({low_power, breq_n, sysclk_run}, 3'b011);
		rstn = 1'b1;
		enter(1'b0, 1'b0);
		wake();
		give_verdict();
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
endmodule
